// [rtl/meter_serial_command_parser.v]
// Serial command parser for the meter: decodes commands, formats replies, APB setup
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ns
`include "cmd_parser_consts.vh"

module meter_serial_command_parser #(
	parameter [22:0] STAR_CYC   = `DLY_STAR_US * `CLK_MHZ,
	parameter [22:0] DOLLAR_CYC = `DLY_DOLLAR_US * `CLK_MHZ
)(
	// Clock and reset
	input  wire               pclk,
	input  wire               presetn,
	// APB slave
	input  wire               psel,
	input  wire               penable,
	input  wire               pwrite,
	input  wire [7:0]         paddr,
	input  wire [31:0]        pwdata,
	output wire               pready,
	output reg  [31:0]        prdata,
	output reg                pslverr,
	// Character stream from the UART receiver
	input  wire [7:0]         rx_data,
	input  wire               rx_valid,
	// Character stream to the UART transmitter
	output reg  [7:0]         tx_data,
	output reg                tx_valid,
	input  wire               tx_ready,
	output wire               tx_parity,
	// Values from the measurement logic
	input  wire signed [19:0] measured_value,
	input  wire signed [19:0] max_value,
	input  wire signed [19:0] min_value,
	// Setpoints and clear pulses to the measurement and output logic
	output reg  signed [19:0] threshold_one,
	output reg  signed [19:0] threshold_two,
	output reg  [4:0]         value_clear
);

// ************************************************************
// State codes
// ************************************************************
localparam P_IDLE = 3'd0, P_ADDR = 3'd1, P_REG = 3'd2, P_DATA = 3'd3;
localparam P_TERM = 3'd4, P_SKIP = 3'd5;
localparam Q_IDLE = 3'd0, Q_WAIT = 3'd1, Q_PICK = 3'd2, Q_CONV = 3'd3, Q_SEND = 3'd4;

// ************************************************************
// Declarations
// ************************************************************
reg  [6:0]   node_r;
reg          abbr_r;
reg  [4:0]   sel_r;
reg          all_r;
reg  [1:0]   en_r;
reg  [1:0]   par_r;
reg  [2:0]   pst_r;
reg          had_r;
reg  [6:0]   nad_r;
reg  [2:0]   nd_r;
reg  [7:0]   cmd_r;
reg  [2:0]   reg_r;
reg          dneg_r;
reg          seen_r;
reg  [16:0]  acc_r;
reg  [2:0]   qst_r;
reg  [22:0]  cnt_r;
reg  [4:0]   mask_r;
reg          blk_r;
reg  [2:0]   p_r;
reg  [16:0]  work_r;
reg  [19:0]  dig_r;
reg          neg_r;
reg          ovf_r;
reg          last_r;
reg  [4:0]   pos_r;
reg  [2:0]   idx_r;
reg  [159:0] line;
reg  [4:0]   len;
reg  [2:0]   lo;
reg  signed [19:0] vsel;
reg  [16:0]  pw;
integer      k;
integer      f;
integer      base;

wire [7:0]   c       = {1'b0, rx_data[6:0]};
wire         rx_take = rx_valid && (qst_r == Q_IDLE);
wire         is_term = (c == `CH_STAR) || (c == `CH_DOLLAR);
wire         is_dig  = (c >= `CH_ZERO) && (c <= `CH_NINE);
wire [3:0]   dval    = c[3:0];
wire         is_cmd  = (c == `CH_READ) || (c == `CH_WRITE) || (c == `CH_CLEAR)
	|| (c == `CH_PRINT);
wire         is_reg  = (c >= `CH_REG_A) && (c <= `CH_REG_E);
wire [2:0]   rid     = c[2:0] - 3'd1;
wire [9:0]   nad10   = {3'b000, nad_r} * 10'd10 + {6'h00, dval};
wire [19:0]  acc10   = {3'b000, acc_r} * 20'd10 + {16'h0000, dval};
wire         amatch  = had_r ? (nad_r == node_r) : (node_r == 7'h00);
wire         cmd_ok  = (pst_r == P_TERM) || ((pst_r == P_DATA) && seen_r);
wire [4:0]   active  = {en_r, 3'b111};
wire [4:0]   pmask   = (sel_r | {5{all_r}}) & active;
wire [6:0]   ntens   = node_r / 7'd10;
wire [6:0]   nones   = node_r % 7'd10;
wire [19:0]  vabs    = vsel[19] ? -vsel : vsel;
wire [4:0]   rest    = mask_r & ~(5'h01 << lo);
wire         apb_wr  = psel && penable && pwrite;

assign pready    = 1'b1;
// Mark parity when none is chosen, so the frame keeps its length
assign tx_parity = (par_r == `PAR_EVEN) ? ^tx_data[6:0] :
	(par_r == `PAR_ODD) ? ~^tx_data[6:0] : 1'b1;

// ************************************************************
// APB registers
// ************************************************************
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		node_r  <= `RST_NODE;
		abbr_r  <= 1'b0;
		sel_r   <= `RST_SEL;
		all_r   <= 1'b0;
		en_r    <= 2'b00;
		par_r   <= 2'b00;
		prdata  <= 32'h0000_0000;
		pslverr <= 1'b0;
	end
	else
	begin
		if (apb_wr && (paddr == `OFS_CTRL))
		begin
			if (pwdata[`CTRL_ADDR_LSB +: 7] <= `ADDR_MAX)
				node_r <= pwdata[`CTRL_ADDR_LSB +: 7];
			abbr_r <= pwdata[`CTRL_ABBR];
			sel_r  <= pwdata[`CTRL_SEL_LSB +: 5];
			all_r  <= pwdata[`CTRL_ALL];
			en_r   <= pwdata[`CTRL_EN_LSB +: 2];
			par_r  <= pwdata[`CTRL_PAR_LSB +: 2];
		end
		// Read data is captured in the setup cycle so it comes from flops
		if (psel && !penable)
		begin
			pslverr <= 1'b0;
			case (paddr)
			`OFS_CTRL:    prdata <= {14'h0000, par_r, en_r, all_r, sel_r, abbr_r, node_r};
			`OFS_THR_ONE: prdata <= {{12{threshold_one[19]}}, threshold_one};
			`OFS_THR_TWO: prdata <= {{12{threshold_two[19]}}, threshold_two};
			`OFS_STATUS:  prdata <= {26'h000_0000, qst_r, pst_r};
			default:
			begin
				prdata  <= 32'h0000_0000;
				pslverr <= 1'b1;
			end
			endcase
		end
	end
end

// ************************************************************
// Command parser
// ************************************************************
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		pst_r         <= P_IDLE;
		had_r         <= 1'b0;
		nad_r         <= 7'h00;
		nd_r          <= 3'd0;
		cmd_r         <= 8'h00;
		reg_r         <= 3'd0;
		dneg_r        <= 1'b0;
		seen_r        <= 1'b0;
		acc_r         <= 17'h0_0000;
		threshold_one <= `RST_THR;
		threshold_two <= `RST_THR;
		value_clear   <= 5'h00;
	end
	else
	begin
		value_clear <= 5'h00;
		if (apb_wr && (paddr == `OFS_THR_ONE))
			threshold_one <= pwdata[19:0];
		if (apb_wr && (paddr == `OFS_THR_TWO))
			threshold_two <= pwdata[19:0];
		if (rx_take && is_term)
		begin
			// Only now is anything acted on; bad strings just vanish
			if (cmd_ok && amatch)
			begin
				if (cmd_r == `CH_WRITE)
				begin
					if (reg_r == 3'd3)
						threshold_one <= dneg_r ? -{3'b000, acc_r} : {3'b000, acc_r};
					else
						threshold_two <= dneg_r ? -{3'b000, acc_r} : {3'b000, acc_r};
				end
				if (cmd_r == `CH_CLEAR)
					value_clear <= 5'h01 << reg_r;
			end
			pst_r  <= P_IDLE;
			had_r  <= 1'b0;
			nd_r   <= 3'd0;
			nad_r  <= 7'h00;
			acc_r  <= 17'h0_0000;
			dneg_r <= 1'b0;
			seen_r <= 1'b0;
		end
		else if (rx_take)
		begin
			case (pst_r)
			P_IDLE, P_ADDR:
			begin
				if ((pst_r == P_IDLE) && (c == `CH_NODE))
					pst_r <= P_ADDR;
				else if ((pst_r == P_ADDR) && is_dig && (nd_r < 3'd2))
				begin
					nad_r <= nad10[6:0];
					nd_r  <= nd_r + 3'd1;
				end
				else if (is_cmd && ((pst_r == P_IDLE) || (nd_r != 3'd0)))
				begin
					had_r <= (pst_r == P_ADDR);
					nd_r  <= 3'd0;
					cmd_r <= c;
					pst_r <= (c == `CH_PRINT) ? P_TERM : P_REG;
				end
				else
					pst_r <= P_SKIP;
			end
			P_REG:
			begin
				reg_r <= rid;
				if (!is_reg || ((cmd_r == `CH_WRITE) && (rid < 3'd3)))
					pst_r <= P_SKIP;
				else
					pst_r <= (cmd_r == `CH_WRITE) ? P_DATA : P_TERM;
			end
			P_DATA:
			begin
				if ((c == `CH_MINUS) && !seen_r && !dneg_r)
					dneg_r <= 1'b1;
				else if (c == `CH_DOT)
					pst_r <= P_DATA;
				else if (is_dig && (dval == 4'h0) && (nd_r == 3'd0))
					seen_r <= 1'b1;
				else if (is_dig && (nd_r < (dneg_r ? 3'd4 : 3'd5)))
				begin
					seen_r <= 1'b1;
					nd_r   <= nd_r + 3'd1;
					acc_r  <= acc10[16:0];
				end
				else
					pst_r <= P_SKIP;
			end
			P_TERM:  pst_r <= P_SKIP;
			default: pst_r <= P_SKIP;
			endcase
		end
	end
end

// ************************************************************
// Reply line builder
// ************************************************************
always @*
begin
	lo = 3'd4;
	for (k = 4; k >= 0; k = k - 1)
		if (mask_r[k])
			lo = k[2:0];
	case (lo)
	3'd0:    vsel = measured_value;
	3'd1:    vsel = max_value;
	3'd2:    vsel = min_value;
	3'd3:    vsel = threshold_one;
	default: vsel = threshold_two;
	endcase
	case (p_r)
	3'd0:    pw = 17'h0_2710;
	3'd1:    pw = 17'h0_03E8;
	3'd2:    pw = 17'h0_0064;
	3'd3:    pw = 17'h0_000A;
	default: pw = 17'h0_0001;
	endcase
	for (k = 0; k < 20; k = k + 1)
		line[8*k +: 8] = `CH_SP;
	base = abbr_r ? 0 : 6;
	if (!abbr_r)
	begin
		if (node_r != 7'h00)
		begin
			line[7:0]  = {4'h3, ntens[3:0]};
			line[15:8] = {4'h3, nones[3:0]};
		end
		// Label comes from idx_r, the value now on the line, so each block print line is named right
		case (idx_r)
		3'd0:    {line[31:24], line[39:32], line[47:40]} = `LBL_0;
		3'd1:    {line[31:24], line[39:32], line[47:40]} = `LBL_1;
		3'd2:    {line[31:24], line[39:32], line[47:40]} = `LBL_2;
		3'd3:    {line[31:24], line[39:32], line[47:40]} = `LBL_3;
		default: {line[31:24], line[39:32], line[47:40]} = `LBL_4;
		endcase
	end
	f = 4;
	for (k = 3; k >= 0; k = k - 1)
		if (dig_r[4*k +: 4] != 4'h0)
			f = k;
	// Value field is nine wide, right-aligned, minus just before the digits
	for (k = 0; k < 5; k = k + 1)
		if (ovf_r)
			line[8*(base+4+k) +: 8] = `CH_DOT;
		else if (k >= f)
			line[8*(base+4+k) +: 8] = {4'h3, dig_r[4*k +: 4]};
	if (neg_r && !ovf_r)
		line[8*(base+3+f) +: 8] = `CH_MINUS;
	line[8*(base+9) +: 8] = `CH_CR;
	line[8*(base+10) +: 8] = `CH_LF;
	if (last_r)
	begin
		line[8*(base+12) +: 8] = `CH_CR;
		line[8*(base+13) +: 8] = `CH_LF;
	end
	len = abbr_r ? (last_r ? 5'd14 : 5'd11) : (last_r ? 5'd20 : 5'd17);
end

// ************************************************************
// Reply sequencer
// ************************************************************
always @(posedge pclk or negedge presetn)
begin
	if (!presetn)
	begin
		qst_r    <= Q_IDLE;
		cnt_r    <= 23'h00_0000;
		mask_r   <= 5'h00;
		blk_r    <= 1'b0;
		p_r      <= 3'd0;
		work_r   <= 17'h0_0000;
		dig_r    <= 20'h0_0000;
		neg_r    <= 1'b0;
		ovf_r    <= 1'b0;
		last_r   <= 1'b0;
		pos_r    <= 5'd0;
		idx_r    <= 3'd0;
		tx_data  <= 8'h00;
		tx_valid <= 1'b0;
	end
	else
	begin
		if (tx_valid && tx_ready)
			tx_valid <= 1'b0;
		case (qst_r)
		Q_IDLE:
		begin
			if (rx_take && is_term && cmd_ok && amatch &&
				((cmd_r == `CH_READ) || (cmd_r == `CH_PRINT)))
			begin
				mask_r <= (cmd_r == `CH_PRINT) ? pmask : (5'h01 << reg_r);
				blk_r  <= (cmd_r == `CH_PRINT);
				// The delay leaves room for the host to release a shared line
				cnt_r  <= (c == `CH_STAR) ? STAR_CYC : DOLLAR_CYC;
				qst_r  <= Q_WAIT;
			end
		end
		Q_WAIT:
		begin
			if (cnt_r <= 23'd1)
				qst_r <= Q_PICK;
			else
				cnt_r <= cnt_r - 23'd1;
		end
		Q_PICK:
		begin
			if (mask_r == 5'h00)
				qst_r <= Q_IDLE;
			else
			begin
				mask_r <= rest;
				idx_r  <= lo;
				neg_r  <= vsel[19];
				ovf_r  <= vabs > {3'b000, `VAL_LIMIT};
				work_r <= vabs[16:0];
				last_r <= blk_r && (rest == 5'h00);
				p_r    <= 3'd0;
				dig_r  <= 20'h0_0000;
				qst_r  <= Q_CONV;
			end
		end
		Q_CONV:
		begin
			// Repeated subtraction: slow but tiny, and far below a byte time
			if (p_r == 3'd5)
			begin
				pos_r <= 5'd0;
				qst_r <= Q_SEND;
			end
			else if (work_r >= pw)
			begin
				work_r <= work_r - pw;
				dig_r[4*p_r +: 4] <= dig_r[4*p_r +: 4] + 4'h1;
			end
			else
				p_r <= p_r + 3'd1;
		end
		Q_SEND:
		begin
			if (!tx_valid || tx_ready)
			begin
				if (pos_r < len)
				begin
					tx_data  <= line[8*pos_r +: 8];
					tx_valid <= 1'b1;
					pos_r    <= pos_r + 5'd1;
				end
				else
					qst_r <= Q_PICK;
			end
		end
		default: qst_r <= Q_IDLE;
		endcase
	end
end

endmodule // meter_serial_command_parser

// [rtl/cmd_parser_consts.vh]
// Constants for the serial command parser: APB map, fields, characters, timing
`ifndef CMD_PARSER_CONSTS_VH
`define CMD_PARSER_CONSTS_VH

// ************************************************************
// APB register offsets (byte addresses)
// ************************************************************
`define OFS_CTRL      8'h00
`define OFS_THR_ONE   8'h04
`define OFS_THR_TWO   8'h08
`define OFS_STATUS    8'h0C

// ************************************************************
// Control register fields and reset values
// ************************************************************
`define CTRL_ADDR_LSB 0
`define CTRL_ABBR     7
`define CTRL_SEL_LSB  8
`define CTRL_ALL      13
`define CTRL_EN_LSB   14
`define CTRL_PAR_LSB  16
`define RST_NODE      7'h00
`define RST_SEL       5'h01
`define RST_THR       20'h0_0000
`define ADDR_MAX      7'h63
`define PAR_ODD       2'h1
`define PAR_EVEN      2'h2

// ************************************************************
// Characters on the link
// ************************************************************
`define CH_NODE       8'h4E
`define CH_READ       8'h54
`define CH_WRITE      8'h56
`define CH_CLEAR      8'h52
`define CH_PRINT      8'h50
`define CH_STAR       8'h2A
`define CH_DOLLAR     8'h24
`define CH_MINUS      8'h2D
`define CH_DOT        8'h2E
`define CH_SP         8'h20
`define CH_CR         8'h0D
`define CH_LF         8'h0A
`define CH_REG_A      8'h41
`define CH_REG_E      8'h45
`define CH_ZERO       8'h30
`define CH_NINE       8'h39
// Reply labels, first character in the top byte
`define LBL_0         24'h49_4E50
`define LBL_1         24'h4D_4158
`define LBL_2         24'h4D_494E
`define LBL_3         24'h53_5031
`define LBL_4         24'h53_5032
`define VAL_LIMIT     17'h1_869F

// ************************************************************
// Reply delay after the terminator
// ************************************************************
`define CLK_MHZ       100
`define DLY_STAR_US   50000
`define DLY_DOLLAR_US 2000

`endif

// [dv/cmd_parser_monitor.sv]
// Checker of the command parser ports
`timescale 1ns/1ns
`include "cmd_parser_consts.vh"
module cmd_parser_monitor #(
	parameter [22:0] STAR_CYC   = 23'h00_0028,
	parameter [22:0] DOLLAR_CYC = 23'h00_0008
)(
	// Clock and reset
	input wire               pclk,
	input wire               presetn,
	// APB
	input wire               psel,
	input wire               penable,
	input wire               pwrite,
	input wire [7:0]         paddr,
	input wire [31:0]        pwdata,
	input wire               pready,
	input wire               pslverr,
	// Character streams
	input wire [7:0]         rx_data,
	input wire               rx_valid,
	input wire [7:0]         tx_data,
	input wire               tx_valid,
	input wire               tx_ready,
	input wire               tx_parity,
	// Setpoints and clears
	input wire signed [19:0] threshold_one,
	input wire signed [19:0] threshold_two,
	input wire [4:0]         value_clear
);
	// ********
	// Helpers
	// ********
	wire       term = rx_valid && ({1'b0, rx_data[6:0]} == `CH_STAR ||
		{1'b0, rx_data[6:0]} == `CH_DOLLAR);
	wire       wr   = psel && penable && pwrite;
	wire       thr  = paddr == `OFS_THR_ONE || paddr == `OFS_THR_TWO;
	wire       mapd = paddr == `OFS_CTRL || thr || paddr == `OFS_STATUS;
	reg [22:0] cnt_r;
	reg [6:0]  idle_r;
	reg        star_r;
	reg        started_r;
	reg [1:0]  par_r;
	// Terminators that arrive mid-reply are ignored here too, so they do not restart the count
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cnt_r     <= 23'h00_0000;
			idle_r    <= 7'h7F;
			star_r    <= 1'b0;
			started_r <= 1'b1;
			par_r     <= 2'h0;
		end
		else
		begin
			if (wr && paddr == `OFS_CTRL)
				par_r <= pwdata[17:16];
			idle_r <= tx_valid ? 7'h00 : (idle_r == 7'h7F ? idle_r : idle_r + 7'h01);
			if (cnt_r != 23'h7F_FFFF)
				cnt_r <= cnt_r + 23'h00_0001;
			if (tx_valid)
				started_r <= 1'b1;
			if (term && idle_r > 7'h3C)
			begin
				cnt_r     <= 23'h00_0000;
				star_r    <= {1'b0, rx_data[6:0]} == `CH_STAR;
				started_r <= 1'b0;
			end
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ********
	// Properties
	// ********
	property p_ready;
		psel |-> pready;
	endproperty
	a_ready: assert property (p_ready) else $error("pready low in a transfer");
	property p_err;
		psel && !penable && !mapd |=> pslverr;
	endproperty
	a_err: assert property (p_err) else $error("no error on unmapped access");
	property p_hold;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
	endproperty
	a_hold: assert property (p_hold) else $error("reply byte dropped before accept");
	property p_clear;
		value_clear != 5'h00 |-> $onehot(value_clear) && ($past(term) || $past(term, 2));
	endproperty
	a_clear: assert property (p_clear) else $error("clear pulse without terminator");
	property p_thr;
		$changed(threshold_one) || $changed(threshold_two) |->
			$past(term) || $past(term, 2) || $past(wr && thr);
	endproperty
	a_thr: assert property (p_thr) else $error("setpoint changed without cause");
	property p_delay;
		tx_valid && !started_r |-> cnt_r >= (star_r ? STAR_CYC : DOLLAR_CYC) - 23'h00_0001;
	endproperty
	a_delay: assert property (p_delay) else $error("reply started too early");
	property p_parity;
		tx_valid |-> ((par_r == `PAR_ODD) ? ^{tx_parity, tx_data[6:0]} :
			(par_r == `PAR_EVEN) ? !(^{tx_parity, tx_data[6:0]}) : tx_parity);
	endproperty
	a_parity: assert property (p_parity) else $error("wrong transmit parity");
	property p_busy;
		tx_valid && term |=> value_clear == 5'h00 ##1 value_clear == 5'h00;
	endproperty
	a_busy: assert property (p_busy) else $error("command acted during reply");
	property p_crlf;
		tx_valid && tx_ready && tx_data == `CH_CR |->
			##[1:60] (tx_valid && tx_ready && tx_data == `CH_LF);
	endproperty
	a_crlf: assert property (p_crlf) else $error("line feed missing after return");
endmodule // cmd_parser_monitor

bind meter_serial_command_parser cmd_parser_monitor #(.STAR_CYC(STAR_CYC),
	.DOLLAR_CYC(DOLLAR_CYC)) cmd_parser_monitor_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .rx_data(rx_data), .rx_valid(rx_valid),
	.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_parity(tx_parity),
	.threshold_one(threshold_one), .threshold_two(threshold_two),
	.value_clear(value_clear));

// [dv/host_link_model.sv]
// Far-side host model: takes reply characters with random stalls
`timescale 1ns/1ns
module host_link_model (
	// Clock and reset
	input  wire       pclk,
	input  wire       presetn,
	// Reply stream
	input  wire [7:0] tx_data,
	input  wire       tx_valid,
	output reg        tx_ready,
	// Accepted character
	output reg  [7:0] got_data,
	output reg        got_valid
);
	integer seed = 32'h0000_f814;
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tx_ready  <= 1'b0;
			got_valid <= 1'b0;
			got_data  <= 8'h00;
		end
		else
		begin
			got_valid <= tx_valid && tx_ready;
			got_data  <= tx_data;
			tx_ready  <= ($random(seed) & 3) != 0;
		end
	end
endmodule // host_link_model

// [dv/test_meter_serial_command_parser.sv]
// Self-checking bench for the serial command parser
`timescale 1ns/1ns
module test_meter_serial_command_parser;
	// ********
	// Signals
	// ********
	reg                pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rx_valid = 0;
	reg         [7:0]  paddr = 0, rx_data = 0, ch;
	reg         [31:0] pwdata = 0;
	reg  signed [19:0] measured_value = 0, max_value = 0, min_value = 0;
	wire               pready, pslverr, tx_valid, tx_ready, tx_parity, got_valid;
	wire        [31:0] prdata;
	wire        [7:0]  tx_data, got_data;
	wire signed [19:0] threshold_one, threshold_two;
	wire        [4:0]  value_clear;
	integer            seed = 32'h0000_f814, failures = 0, tests_run = 0, node = 0, abbr = 0, i;
	logic       [7:0]  exp_q[$];
	logic       [4:0]  clr_q[$];
	logic       [31:0] rd;
	logic              er;
	always #5 pclk = ~pclk;
	meter_serial_command_parser #(.STAR_CYC(23'h00_0028), .DOLLAR_CYC(23'h00_0008))
		meter_serial_command_parser_i (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .rx_data(rx_data), .rx_valid(rx_valid),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_parity(tx_parity),
		.measured_value(measured_value), .max_value(max_value), .min_value(min_value),
		.threshold_one(threshold_one), .threshold_two(threshold_two),
		.value_clear(value_clear));
	host_link_model host_link_model_i (.pclk(pclk), .presetn(presetn), .tx_data(tx_data),
		.tx_valid(tx_valid), .tx_ready(tx_ready), .got_data(got_data), .got_valid(got_valid));
	// ********
	// Tasks
	// ********
	task results;
		begin
			$display("failures=%0d tests_run=%0d", failures, tests_run);
			if (failures == 0 && tests_run > 0)
				$display("Regression OK");
			else
				$display("Regression broken");
			$finish;
		end
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		begin
			tests_run++;
			if (g !== e)
			begin
				failures++;
				$display("[ERR] %s expected %h seen %h", n, e, g);
			end
		end
	endtask
	task push(input string s);
		foreach (s[k]) exp_q.push_back(s[k]);
	endtask
	task line(input string lbl, input integer v);
		begin
			if (abbr == 0)
				push({node == 0 ? "  " : $sformatf("%02d", node), " ", lbl});
			push({$sformatf("%9d", v), "\r\n"});
		end
	endtask
	// Entered just after a rising edge; request held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		integer n;
		begin
			psel <= 1;
			penable <= 0;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1;
			n = 0;
			do
			begin
				@(posedge pclk);
				n++;
			end
			while (pready !== 1'b1 && n < 50);
			if (n >= 50)
			begin
				failures++;
				results();
			end
			rd = prdata;
			er = pslverr;
			psel <= 0;
			penable <= 0;
			// One idle edge, so a following call never re-drives psel in this time step
			@(posedge pclk);
		end
	endtask
	task send(input string s);
		begin
			foreach (s[k])
			begin
				rx_valid <= 1;
				rx_data <= s[k];
				@(posedge pclk);
			end
			rx_valid <= 0;
			@(posedge pclk);
		end
	endtask
	task drain;
		integer n;
		begin
			n = 0;
			while ((exp_q.size() != 0 || clr_q.size() != 0) && n < 3000)
			begin
				@(posedge pclk);
				n++;
			end
			if (n >= 3000)
			begin
				failures++;
				results();
			end
			repeat (80) @(posedge pclk);
		end
	endtask
	// ********
	// Result watcher
	// ********
	always @(posedge pclk)
	begin
		if (got_valid)
			chk("tx_data", exp_q.size() ? exp_q.pop_front() : 8'hxx, got_data);
		if (value_clear !== 5'h00)
			chk("value_clear", clr_q.size() ? clr_q.pop_front() : 5'h00, value_clear);
	end
	// ********
	// Sequence
	// ********
	initial
	begin
		measured_value <= $unsigned($random(seed)) % 100000;
		max_value <= $unsigned($random(seed)) % 100000;
		min_value <= $unsigned($random(seed)) % 100000;
		repeat (3) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, 8'h00, 0);
		chk("ctrl", 32'h0000_0100, rd);
		apb(1, 8'h08, 32'h0000_0309);
		apb(0, 8'h08, 0);
		chk("thr_two", 32'h0000_0309, rd);
		apb(0, 8'h10, 0);
		chk("unmapped", 32'h0000_0000, rd);
		chk("slverr", 32'h0000_0001, er);
		apb(1, 8'h00, 32'h0000_0164);
		apb(0, 8'h00, 0);
		chk("node_max", 32'h0000_0100, rd);
		send("VD-0250$");
		repeat (3) @(posedge pclk);
		chk("thr_one", -250, 32'(threshold_one));
		send("VE12.5$");
		repeat (3) @(posedge pclk);
		chk("thr_two", 125, 32'(threshold_two));
		send("VD00350$");
		send("VA12$");
		send("TF$");
		send("XA$");
		repeat (3) @(posedge pclk);
		chk("thr_one", 350, 32'(threshold_one));
		chk("thr_two", 125, 32'(threshold_two));
		line("SP1", 350);
		send("TD$");
		drain();
		line("INP", measured_value);
		send("TA$");
		drain();
		apb(1, 8'h00, 32'h0000_0111);
		node = 17;
		line("MAX", max_value);
		send("N17TB*");
		i = 0;
		while (tx_valid !== 1'b1 && i < 500)
		begin
			@(posedge pclk);
			i++;
		end
		if (i >= 500)
		begin
			failures++;
			results();
		end
		send("RA$");
		drain();
		send("TB$");
		drain();
		apb(1, 8'h00, 32'h0000_0191);
		abbr = 1;
		line("MIN", min_value);
		send("N17TC$");
		drain();
		apb(1, 8'h00, 32'h0001_5980);
		node = 0;
		line("INP", measured_value);
		line("SP1", 350);
		push(" \r\n");
		send("P$");
		drain();
		apb(1, 8'h00, 32'h0002_A080);
		line("INP", measured_value);
		line("MAX", max_value);
		line("MIN", min_value);
		line("SP2", 125);
		push(" \r\n");
		send("P*");
		drain();
		for (i = 0; i < 5; i++)
		begin
			ch = 8'h41 + i;
			clr_q.push_back(5'h01 << i);
			send({"R", ch, "$"});
			drain();
		end
		// Full-field block print: labels per line, a negative setpoint, an overflowing value
		apb(1, 8'h04, 32'hFFFF_FB2E);
		apb(1, 8'h00, 32'h0000_E000);
		abbr = 0;
		max_value <= 20'h2_49F0;
		line("INP", measured_value);
		push("   MAX    .....\r\n");
		line("MIN", min_value);
		line("SP1", -1234);
		line("SP2", 125);
		push(" \r\n");
		send("P$");
		drain();
		chk("leftover", 32'h0000_0000, exp_q.size());
		results();
	end
endmodule // test_meter_serial_command_parser
